// ### core/rtc_win_pkg.sv
// Constants and types for the calendar clock register window front end.
// Assumes an Avalon-MM master on the same clock and byte addresses.
//
// What this block does
// - Time pointer picks time window byte pair
// - Time high-byte write decrements pointer, saturating
// - Alarm pointer picks alarm window byte pair
// - Alarm high-byte write decrements pointer, saturating
// - Any alarm window read decrements alarm pointer
// - Any time window read decrements time pointer
// - Time writes ignored unless write enable set
// - Write enable settable only right after 55h/AAh
// - Two-bit field selects one of four references
package rtc_win_pkg;

  // ==========================================
  // Register offsets (byte addresses)
  localparam logic [4:0] CFG_OFS  = 5'h00;
  localparam logic [4:0] TWIN_OFS = 5'h04;
  localparam logic [4:0] ACFG_OFS = 5'h08;
  localparam logic [4:0] AWIN_OFS = 5'h0C;
  localparam logic [4:0] KEY_OFS  = 5'h10;
  localparam logic [4:0] PWC_OFS  = 5'h14;

  // ==========================================
  // Field positions
  localparam int PTR_LSB  = 8;
  localparam int WREN_BIT = 13;
  localparam int CSEL_LSB = 8;

  // ==========================================
  // Key values and reset values
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [1:0] PTR_RST    = 2'h0;
  localparam logic [1:0] CSEL_RST   = 2'h0;
  localparam logic [7:0] BYTE_RST   = 8'h00;

  // ==========================================
  // Clock source codes
  localparam logic [1:0] CSEL_SEC_OSC  = 2'h0;
  localparam logic [1:0] CSEL_LOW_PWR  = 2'h1;
  localparam logic [1:0] CSEL_EXT50 = 2'h2;
  localparam logic [1:0] CSEL_EXT60 = 2'h3;

  // ==========================================
  // Unlock sequencer
  typedef enum logic [2:0] {
    KEY_IDLE  = 3'h1,
    KEY_GOT55 = 3'h2,
    KEY_OPEN  = 3'h4
  } key_type;

  typedef struct packed {
    logic            ack;
    logic [31:0]     rdata;
    logic [7:0]      cal;
    logic [7:0]      arpt;
    logic [1:0]      tptr;
    logic [1:0]      aptr;
    logic            wren;
    logic [1:0]      csel;
    key_type         key;
    logic [7:0][7:0] tval;
    logic [7:0][7:0] aval;
    logic [3:0]      sync1;
    logic [3:0]      sync2;
    logic            ref_tick;
  } state_type;

endpackage

// ### core/rtc_window.sv
// Register window front end of the calendar clock unit.
// Assumes one clock, Avalon-MM master, reference inputs from pins.
module rtc_window
  import rtc_win_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Reference clock pins, asynchronous
  input  wire logic        sosc_in,
  input  wire logic        low_power_rc_in,
  input  wire logic        ext50_in,
  input  wire logic        ext60_in,
  // Selected reference and stored values
  output logic             ref_clk_sel,
  output logic [1:0]       clock_source_select,
  output logic             timer_write_enable,
  output logic [63:0]      time_value,
  output logic [63:0]      alarm_value
);

  state_type s_r;
  state_type s_nxt;

  // ==========================================
  // Helpers
  function automatic logic [1:0] ptr_dec(input logic [1:0] p);
    ptr_dec = (p == PTR_RST) ? PTR_RST : p - 2'h1;
  endfunction

  function automatic logic [2:0] byte_idx(input logic [1:0] p, input logic hi);
    byte_idx = {p, hi};
  endfunction

  logic       acc;
  logic       wr;
  logic       rd;
  logic [2:0] tlo;
  logic [2:0] thi;
  logic [2:0] alo;
  logic [2:0] ahi;

  // ==========================================
  // Combinational next state
  always_comb begin
    s_nxt = s_r;
    // One wait cycle: effects happen once, on the first cycle
    acc = (read | write) & ~s_r.ack;
    wr  = acc & write;
    rd  = acc & read & ~write;
    s_nxt.ack = acc;
    tlo = byte_idx(s_r.tptr, 1'b0);
    thi = byte_idx(s_r.tptr, 1'b1);
    alo = byte_idx(s_r.aptr, 1'b0);
    ahi = byte_idx(s_r.aptr, 1'b1);

    // Pins pass two flops before use
    s_nxt.sync1 = {ext60_in, ext50_in, low_power_rc_in, sosc_in};
    s_nxt.sync2 = s_r.sync1;
    s_nxt.ref_tick = s_r.sync2[s_r.csel];

    if (rd) begin
      s_nxt.rdata = 32'h0000_0000;
      case (address)
        CFG_OFS: begin
          s_nxt.rdata[7:0] = s_r.cal;
          s_nxt.rdata[PTR_LSB +: 2] = s_r.tptr;
          s_nxt.rdata[WREN_BIT] = s_r.wren;
        end
        TWIN_OFS: begin
          // Pair 11 high byte is unused and reads zero
          s_nxt.rdata[7:0] = s_r.tval[tlo];
          s_nxt.rdata[15:8] = (thi == 3'h7) ? BYTE_RST : s_r.tval[thi];
          // Any read width steps the pointer
          s_nxt.tptr = ptr_dec(s_r.tptr);
        end
        ACFG_OFS: begin
          s_nxt.rdata[7:0] = s_r.arpt;
          s_nxt.rdata[PTR_LSB +: 2] = s_r.aptr;
        end
        AWIN_OFS: begin
          s_nxt.rdata[7:0]  = s_r.aval[alo];
          s_nxt.rdata[15:8] = s_r.aval[ahi];
          s_nxt.aptr = ptr_dec(s_r.aptr);
        end
        PWC_OFS: begin
          s_nxt.rdata[CSEL_LSB +: 2] = s_r.csel;
        end
        default: begin
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (wr) begin
      case (address)
        CFG_OFS: begin
          if (byteenable[0]) begin
            s_nxt.cal = writedata[7:0];
          end
          if (byteenable[1]) begin
            s_nxt.tptr = writedata[PTR_LSB +: 2];
            // Clearing is always allowed, setting only when unlocked
            if (!writedata[WREN_BIT] || s_r.key == KEY_OPEN) begin
              s_nxt.wren = writedata[WREN_BIT];
            end
          end
        end
        TWIN_OFS: begin
          if (s_r.wren) begin
            if (byteenable[0]) begin
              s_nxt.tval[tlo] = writedata[7:0];
            end
            if (byteenable[1]) begin
              if (thi != 3'h7) begin
                s_nxt.tval[thi] = writedata[15:8];
              end
              s_nxt.tptr = ptr_dec(s_r.tptr);
            end
          end
        end
        ACFG_OFS: begin
          if (byteenable[0]) begin
            s_nxt.arpt = writedata[7:0];
          end
          if (byteenable[1]) begin
            s_nxt.aptr = writedata[PTR_LSB +: 2];
          end
        end
        AWIN_OFS: begin
          if (byteenable[0]) begin
            s_nxt.aval[alo] = writedata[7:0];
          end
          if (byteenable[1]) begin
            s_nxt.aval[ahi] = writedata[15:8];
            s_nxt.aptr = ptr_dec(s_r.aptr);
          end
        end
        PWC_OFS: begin
          if (byteenable[1]) begin
            s_nxt.csel = writedata[CSEL_LSB +: 2];
          end
        end
        default: begin
          s_nxt.csel = s_r.csel;
        end
      endcase
    end

    // ==========================================
    // Unlock sequencer: window lasts exactly one access
    if (acc) begin
      case (s_r.key)
        KEY_IDLE: begin
          if (wr && address == KEY_OFS && byteenable[0] && writedata[7:0] == KEY_FIRST) begin
            s_nxt.key = KEY_GOT55;
          end
        end
        KEY_GOT55: begin
          if (wr && address == KEY_OFS && byteenable[0] && writedata[7:0] == KEY_SECOND) begin
            s_nxt.key = KEY_OPEN;
          end else if (wr && address == KEY_OFS && byteenable[0] && writedata[7:0] == KEY_FIRST) begin
            s_nxt.key = KEY_GOT55;
          end else begin
            s_nxt.key = KEY_IDLE;
          end
        end
        KEY_OPEN: begin
          s_nxt.key = KEY_IDLE;
        end
        default: begin
          s_nxt.key = KEY_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r.ack      <= 1'b0;
      s_r.rdata    <= 32'h0000_0000;
      s_r.cal      <= BYTE_RST;
      s_r.arpt     <= BYTE_RST;
      s_r.tptr     <= PTR_RST;
      s_r.aptr     <= PTR_RST;
      s_r.wren     <= 1'b0;
      s_r.csel     <= CSEL_RST;
      s_r.key      <= KEY_IDLE;
      s_r.tval     <= 64'h0000_0000_0000_0000;
      s_r.aval     <= 64'h0000_0000_0000_0000;
      s_r.sync1    <= 4'h0;
      s_r.sync2    <= 4'h0;
      s_r.ref_tick <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign waitrequest         = (read | write) & ~s_r.ack;
  assign readdata            = s_r.rdata;
  assign ref_clk_sel         = s_r.ref_tick;
  assign clock_source_select = s_r.csel;
  assign timer_write_enable  = s_r.wren;
  assign time_value          = s_r.tval;
  assign alarm_value         = s_r.aval;

endmodule // rtc_window

// ### sim/rtc_window_monitor.sv
// Checker for the register window front end.
// Assumes one clock; bound to rtc_window below.
module rtc_window_chk
  import rtc_win_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Bus
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Pins and state
  input wire logic        sosc_in,
  input wire logic        low_power_rc_in,
  input wire logic        ext50_in,
  input wire logic        ext60_in,
  input wire logic        ref_clk_sel,
  input wire logic [1:0]  clock_source_select,
  input wire logic        timer_write_enable,
  input wire logic [63:0] time_value,
  input wire logic [63:0] alarm_value
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ======================
  // Pin history, three edges deep
  logic [11:0] pin_r;
  always_ff @(posedge clk) begin
    pin_r <= {pin_r[7:0], ext60_in, ext50_in, low_power_rc_in, sosc_in};
  end
  // ======================
  // Properties
  sequence s_rd_void;
    read && waitrequest && (address == KEY_OFS || address > PWC_OFS);
  endsequence
  property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
  property p_rdata; !(read && waitrequest) |=> $stable(readdata); endproperty
  property p_void; s_rd_void |=> readdata == 32'h0; endproperty
  property p_tlock;
    !(write && waitrequest && address == TWIN_OFS && timer_write_enable) |=> $stable(time_value);
  endproperty
  property p_ahold;
    !(write && waitrequest && address == AWIN_OFS) |=> $stable(alarm_value);
  endproperty
  property p_csel; !(write && waitrequest && address == PWC_OFS) |=> $stable(clock_source_select);
  endproperty
  property p_wren; $rose(timer_write_enable) |->
    $past(write && waitrequest && address == CFG_OFS && writedata[WREN_BIT]); endproperty
  property p_ref; $past(rstn, 3) && $stable(clock_source_select)
    && clock_source_select == $past(clock_source_select, 2)
    |-> ref_clk_sel == pin_r[{2'b10, clock_source_select}]; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  a_rdata: assert property (p_rdata) else $error("read data moved without read");
  a_void: assert property (p_void) else $error("unmapped read not zero");
  a_tlock: assert property (p_tlock) else $error("time changed while locked");
  a_ahold: assert property (p_ahold) else $error("alarm changed without write");
  a_csel: assert property (p_csel) else $error("source changed without write");
  a_wren: assert property (p_wren) else $error("enable set without write");
  a_ref: assert property (p_ref) else $error("wrong reference selected");
endmodule // rtc_window_chk

bind rtc_window rtc_window_chk chk_u (.clk, .rstn, .address, .read, .write, .writedata,
  .readdata, .waitrequest, .sosc_in, .low_power_rc_in, .ext50_in, .ext60_in, .ref_clk_sel,
  .clock_source_select, .timer_write_enable, .time_value, .alarm_value);

// ### sim/testbench.sv
// Self-checking bench for the register window front end.
// Assumes rtc_window and its checker are compiled first.
module testbench import rtc_win_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
  logic [4:0]  address = 5'h00;
  logic [3:0]  byteenable = 4'h0, pins = 4'h0, be;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic        waitrequest, ref_clk_sel, timer_write_enable;
  logic [1:0]  clock_source_select;
  logic [63:0] time_value, alarm_value;
  logic [15:0] m;
  logic [15:0] tab [2][5] = '{'{16'h0050, 16'hA151, 16'hA252, 16'hA454, 16'hA454},
                              '{16'hC060, 16'hC161, 16'hC262, 16'hC464, 16'hC464}};
  int          error_cnt = 0, tests_run = 0;
  always #20 clk = ~clk;
  rtc_window dut_u (.clk, .rstn, .address, .read, .write, .byteenable, .writedata,
    .readdata, .waitrequest, .sosc_in(pins[0]), .low_power_rc_in(pins[1]), .ext50_in(pins[2]),
    .ext60_in(pins[3]), .ref_clk_sel, .clock_source_select, .timer_write_enable,
    .time_value, .alarm_value);
  // ======================
  // Bus and compare tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    byteenable <= b;
    // No cycle count assumed; only the watchdog ends a hung wait
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic print_verdict;
    $display("Errors %0d in %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ======================
  // Scenarios
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    bus(0, CFG_OFS, 32'h0, 4'h3);
    chk(rd, 32'h0);
    bus(1, CFG_OFS, 32'h2300, 4'h3);
    chk(timer_write_enable, 1'b0);
    bus(1, TWIN_OFS, 32'hFFFF, 4'h3);
    chk(time_value, 64'h0);
    bus(0, CFG_OFS, 32'h0, 4'h3);
    chk(rd[9:8], 2'h3);
    bus(1, KEY_OFS, 32'h55, 4'h1);
    bus(0, 5'h18, 32'h0, 4'h3);
    chk(rd, 32'h0);
    bus(1, KEY_OFS, 32'hAA, 4'h1);
    bus(1, CFG_OFS, 32'h2300, 4'h3);
    chk(timer_write_enable, 1'b0);
    // Unlock lasts one access only, even a read
    bus(1, KEY_OFS, 32'h55, 4'h1);
    bus(1, KEY_OFS, 32'hAA, 4'h1);
    bus(0, CFG_OFS, 32'h0, 4'h3);
    bus(1, CFG_OFS, 32'h2300, 4'h3);
    chk(timer_write_enable, 1'b0);
    for (int u = 0; u < 2; u++) begin
      bus(1, KEY_OFS, 32'h55, 4'h1);
      // Repeated first key restarts the sequence
      if (u == 0)
        bus(1, KEY_OFS, 32'h55, 4'h1);
      bus(1, KEY_OFS, 32'hAA, 4'h1);
      bus(1, u ? ACFG_OFS : CFG_OFS, u ? 32'h0300 : 32'h2300, 4'h3);
      chk(timer_write_enable, !u);
      for (int i = 0; i < 5; i++)
        bus(1, u ? AWIN_OFS : TWIN_OFS, 32'h0101 * i + (u ? 32'hC060 : 32'hA050), 4'h3);
      chk(u ? alarm_value : time_value, u ? 64'hC060_C161_C262_C464
          : 64'h0050_A151_A252_A454);
      bus(1, u ? ACFG_OFS : CFG_OFS, 32'h0300, 4'h3);
      chk(timer_write_enable, 1'b0);
      for (int k = 0; k < 5; k++) begin
        be = k[0] ? 4'h1 : 4'h2;
        m = {{8{be[1]}}, {8{be[0]}}};
        bus(0, u ? AWIN_OFS : TWIN_OFS, 32'h0, be);
        chk(rd[15:0] & m, tab[u][k] & m);
      end
    end
    for (int c = 0; c < 4; c++) begin
      bus(1, PWC_OFS, c << 8, 4'h3);
      chk(clock_source_select, c[1:0]);
      pins <= 4'h1 << c;
      repeat (5) @(posedge clk);
      chk(ref_clk_sel, 1'b1);
      pins <= ~(4'h1 << c);
      repeat (5) @(posedge clk);
      chk(ref_clk_sel, 1'b0);
    end
    print_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end
endmodule // testbench
